//--- rtl/pwm_cfg_pkg.sv
// constants shared by the pwm configuration block and its helpers
// assumes byte-wide and 16-bit configuration registers carried in 32-bit apb words
package pwm_cfg_pkg;

  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned REG_W   = 8;
  localparam int unsigned TB_W    = 16;
  localparam int unsigned NOUT    = 6;
  localparam int unsigned NCMP    = 4;
  localparam int unsigned BLANK_W = 8;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CLOCK_SELECT_PRESCALE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_ENABLE         = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_POLARITY       = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_BLANKING_MODE         = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_RISING_BLANK_SOURCES  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FALLING_BLANK_SOURCES = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_RISING_EVENT_SOURCES  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PHASE_VALUE           = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_PERIOD_VALUE          = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_DUTY_VALUE            = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_BLANK_TIME            = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_TIMEBASE_CONTROL      = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_STATUS                = 8'h30;

  // implemented bits of each byte register
  localparam logic [REG_W-1:0] MASK_CLK      = 8'h33;
  localparam logic [REG_W-1:0] MASK_OEN      = 8'h3F;
  localparam logic [REG_W-1:0] MASK_OEN_TWO  = 8'h03;
  localparam logic [REG_W-1:0] MASK_POL      = 8'h7F;
  localparam logic [REG_W-1:0] MASK_POL_TWO  = 8'h43;
  localparam logic [REG_W-1:0] MASK_BLNK     = 8'h33;
  localparam logic [REG_W-1:0] MASK_BLSRC    = 8'h9E;
  localparam logic [REG_W-1:0] MASK_PHS      = 8'h9F;
  localparam logic [REG_W-1:0] MASK_TBCTRL   = 8'h01;
  localparam logic [REG_W-1:0] RESET_BYTE    = 8'h00;

  // field positions
  localparam int unsigned PRE_LSB    = 4;
  localparam int unsigned SRC_LSB    = 0;
  localparam int unsigned FEBM_LSB   = 4;
  localparam int unsigned REBM_LSB   = 0;
  localparam int unsigned POLIN_BIT  = 6;
  localparam int unsigned PIN_BIT    = 7;
  localparam int unsigned CMP_LSB    = 1;
  localparam int unsigned TB_BIT     = 0;
  localparam int unsigned PRD_TB_BIT = 0;

  typedef enum logic [1:0] {
    SRC_FOSC = 2'b00,
    SRC_PLL  = 2'b01,
    SRC_PIN  = 2'b10,
    SRC_RSVD = 2'b11
  } clk_src_t;

  typedef enum logic [1:0] {
    BLANK_NONE      = 2'b00,
    BLANK_IMMEDIATE = 2'b01,
    BLANK_RSVD2     = 2'b10,
    BLANK_RSVD3     = 2'b11
  } blank_mode_t;

endpackage

//--- rtl/input_sync.sv
// two-flop synchroniser for a group of independent level inputs
// assumes each bit is a slow level; no bus coherence between bits
`timescale 1ns/1ps
module input_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

//--- rtl/clock_tick_gen.sv
// controller clock tick: picks a source tick and divides it by 1/2/4/8
// assumes pll_tick is a one-cycle pulse in pclk and ext_edge is already synchronised
`timescale 1ns/1ps
module clock_tick_gen
  import pwm_cfg_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire pwm_cfg_pkg::clk_src_t src_sel,
  input  wire logic [1:0]           pre_sel,
  input  wire logic                 pll_tick,
  input  wire logic                 ext_edge,
  output logic                      tick
);
  logic       src_tick;
  logic [2:0] div_cnt;
  logic [2:0] div_limit;

  // [R02] source choice
  always_comb
  begin
    case (src_sel)
      SRC_FOSC: src_tick = 1'b1;
      SRC_PLL:  src_tick = pll_tick;
      SRC_PIN:  src_tick = ext_edge;
      // reserved code stops the controller clock
      default:  src_tick = 1'b0;
    endcase
  end

  // [R01] divide by power of two
  assign div_limit = 3'((4'h1 << pre_sel) - 4'h1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt <= 3'h0;
      tick    <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (src_tick)
      begin
        if (div_cnt >= div_limit)
        begin
          div_cnt <= 3'h0;
          tick    <= 1'b1;
        end
        else
        begin
          div_cnt <= div_cnt + 3'h1;
        end
      end
    end
  end
endmodule

//--- rtl/pwm_config.sv
// configuration, event sources and blanking of one switch mode pwm controller
// assumes an apb master on pclk; pins and comparator outputs are asynchronous
// Functional notes
// [R01] prescaler divides controller clock by 1/2/4/8
// [R02] source field picks fosc, pll or pin
// [R03] enable bit hands pin to pwm
// [R04] input polarity bit inverts external input
// [R05] polarity bit makes output active low
// [R06] second instance keeps only outputs a, b
// [R07] falling blank mode: none or immediate
// [R08] rising blank mode: none or immediate
// [R09] rising blank sources suppressed during interval
// [R10] falling blank sources suppressed during interval
// [R11] selected pin/comparator going true sets rise
// [R12] timebase equal phase makes rise event
// [R13] rise event sources are ored
// [R14] unimplemented bits read zero, ignore writes
// [R15] all configuration bits reset to zero
// [R16] period match resets timebase, period event
// [R17] sources edge detected on controller clock
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module pwm_config
  import pwm_cfg_pkg::*;
#(
  parameter bit SECOND_INSTANCE = 1'b0
) (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [pwm_cfg_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [pwm_cfg_pkg::DATA_W-1:0]    pwdata,
  output logic      [pwm_cfg_pkg::DATA_W-1:0]    prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic                              pll_tick,
  input  wire logic                              ext_clock_pin,
  input  wire logic                              external_event_input,
  input  wire logic [pwm_cfg_pkg::NCMP-1:0]      comparator_sync_out,
  output logic      [pwm_cfg_pkg::NOUT-1:0]      pwm_out,
  output logic      [pwm_cfg_pkg::NOUT-1:0]      pwm_drive_en,
  output logic                                   rise_event,
  output logic                                   fall_event,
  output logic                                   period_event
);
  import pwm_cfg_pkg::*;

  localparam logic [REG_W-1:0] OEN_MASK = SECOND_INSTANCE ? MASK_OEN_TWO : MASK_OEN;
  localparam logic [REG_W-1:0] POL_MASK = SECOND_INSTANCE ? MASK_POL_TWO : MASK_POL;

  logic [REG_W-1:0]   clock_select_prescale;
  logic [REG_W-1:0]   output_enable;
  logic [REG_W-1:0]   output_polarity;
  logic [REG_W-1:0]   blanking_mode;
  logic [REG_W-1:0]   rising_blank_sources;
  logic [REG_W-1:0]   falling_blank_sources;
  logic [REG_W-1:0]   rising_event_sources;
  logic [REG_W-1:0]   timebase_control;
  logic [TB_W-1:0]    phase_value;
  logic [TB_W-1:0]    period_value;
  logic [TB_W-1:0]    duty_value;
  logic [2*BLANK_W-1:0] blank_time;

  logic [TB_W-1:0]    timebase_counter;
  logic               pwm_level;
  logic [BLANK_W-1:0] rise_blank_cnt;
  logic [BLANK_W-1:0] fall_blank_cnt;

  logic               setup_phase;
  logic               wr_strobe;
  logic [DATA_W-1:0]  next_prdata;
  logic               next_err;

  logic [2+NCMP-1:0]  raw_sync;
  logic               ext_clk_sync;
  logic               pin_sync;
  logic [NCMP-1:0]    cmp_sync;
  logic               ext_clk_prev;
  logic               ctl_tick;

  logic [REG_W-1:0]   src_now;
  logic [REG_W-1:0]   src_prev;
  logic [REG_W-1:0]   src_rise;
  logic [REG_W-1:0]   blocked;
  logic               rise_blank_on;
  logic               fall_blank_on;
  logic               next_rise;
  logic               next_fall;
  logic               next_period;

  // decoding for the error answer only; the read path decodes paddr in its own case
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CLOCK_SELECT_PRESCALE, OFS_OUTPUT_ENABLE, OFS_OUTPUT_POLARITY,
      OFS_BLANKING_MODE, OFS_RISING_BLANK_SOURCES, OFS_FALLING_BLANK_SOURCES,
      OFS_RISING_EVENT_SOURCES, OFS_PHASE_VALUE, OFS_PERIOD_VALUE,
      OFS_DUTY_VALUE, OFS_BLANK_TIME, OFS_TIMEBASE_CONTROL, OFS_STATUS:
        addr_mapped = 1'b1;
      default:
        addr_mapped = 1'b0;
    endcase
  endfunction

  // ---------------- apb slave ----------------
  // answer one cycle after setup so that prdata and pready come from flops
  assign setup_phase = psel && !penable;
  assign wr_strobe   = psel && penable && pready && pwrite && !pslverr;

  always_comb
  begin
    next_prdata = '0;
    case (paddr)
      OFS_CLOCK_SELECT_PRESCALE: next_prdata[REG_W-1:0] = clock_select_prescale;
      OFS_OUTPUT_ENABLE:         next_prdata[REG_W-1:0] = output_enable;
      OFS_OUTPUT_POLARITY:       next_prdata[REG_W-1:0] = output_polarity;
      OFS_BLANKING_MODE:         next_prdata[REG_W-1:0] = blanking_mode;
      OFS_RISING_BLANK_SOURCES:  next_prdata[REG_W-1:0] = rising_blank_sources;
      OFS_FALLING_BLANK_SOURCES: next_prdata[REG_W-1:0] = falling_blank_sources;
      OFS_RISING_EVENT_SOURCES:  next_prdata[REG_W-1:0] = rising_event_sources;
      OFS_TIMEBASE_CONTROL:      next_prdata[REG_W-1:0] = timebase_control;
      OFS_PHASE_VALUE:           next_prdata[TB_W-1:0]  = phase_value;
      OFS_PERIOD_VALUE:          next_prdata[TB_W-1:0]  = period_value;
      OFS_DUTY_VALUE:            next_prdata[TB_W-1:0]  = duty_value;
      OFS_BLANK_TIME:            next_prdata[2*BLANK_W-1:0] = blank_time;
      OFS_STATUS:                next_prdata = {15'h0000, pwm_level, timebase_counter};
      default:                   next_prdata = '0;
    endcase
    next_err = !addr_mapped(paddr);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= setup_phase;
      pslverr <= setup_phase && next_err;
      if (setup_phase && !pwrite)
        prdata <= next_prdata;
    end
  end

  // [R14] writes keep only implemented bits
  // [R15] every configuration bit clears on reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clock_select_prescale <= RESET_BYTE;
      output_enable         <= RESET_BYTE;
      output_polarity       <= RESET_BYTE;
      blanking_mode         <= RESET_BYTE;
      rising_blank_sources  <= RESET_BYTE;
      falling_blank_sources <= RESET_BYTE;
      rising_event_sources  <= RESET_BYTE;
      timebase_control      <= RESET_BYTE;
      phase_value           <= '0;
      period_value          <= '0;
      duty_value            <= '0;
      blank_time            <= '0;
    end
    else if (wr_strobe)
    begin
      case (paddr)
        OFS_CLOCK_SELECT_PRESCALE: clock_select_prescale <= pwdata[REG_W-1:0] & MASK_CLK;
        // [R06] c through f absent on second instance
        OFS_OUTPUT_ENABLE:         output_enable   <= pwdata[REG_W-1:0] & OEN_MASK;
        OFS_OUTPUT_POLARITY:       output_polarity <= pwdata[REG_W-1:0] & POL_MASK;
        OFS_BLANKING_MODE:         blanking_mode   <= pwdata[REG_W-1:0] & MASK_BLNK;
        OFS_RISING_BLANK_SOURCES:  rising_blank_sources  <= pwdata[REG_W-1:0] & MASK_BLSRC;
        OFS_FALLING_BLANK_SOURCES: falling_blank_sources <= pwdata[REG_W-1:0] & MASK_BLSRC;
        OFS_RISING_EVENT_SOURCES:  rising_event_sources  <= pwdata[REG_W-1:0] & MASK_PHS;
        OFS_TIMEBASE_CONTROL:      timebase_control <= pwdata[REG_W-1:0] & MASK_TBCTRL;
        OFS_PHASE_VALUE:           phase_value  <= pwdata[TB_W-1:0];
        OFS_PERIOD_VALUE:          period_value <= pwdata[TB_W-1:0];
        OFS_DUTY_VALUE:            duty_value   <= pwdata[TB_W-1:0];
        OFS_BLANK_TIME:            blank_time   <= pwdata[2*BLANK_W-1:0];
        default:                   ;
      endcase
    end
  end

  // ---------------- pins in, controller clock ----------------
  input_sync #(
    .W (2 + NCMP)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({ext_clock_pin, external_event_input, comparator_sync_out}),
    .sync_out (raw_sync)
  );

  assign ext_clk_sync = raw_sync[NCMP+1];
  assign cmp_sync     = raw_sync[NCMP-1:0];
  // [R04] active-low pin when polarity bit set
  assign pin_sync     = raw_sync[NCMP] ^ output_polarity[POLIN_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_clk_prev <= 1'b0;
    else
      ext_clk_prev <= ext_clk_sync;
  end

  clock_tick_gen u_tick (
    .pclk     (pclk),
    .presetn  (presetn),
    .src_sel  (clk_src_t'(clock_select_prescale[SRC_LSB +: 2])),
    .pre_sel  (clock_select_prescale[PRE_LSB +: 2]),
    .pll_tick (pll_tick),
    .ext_edge (ext_clk_sync && !ext_clk_prev),
    .tick     (ctl_tick)
  );

  // ---------------- event sources ----------------
  // sources laid out in the same bit order as the source registers
  always_comb
  begin
    src_now = '0;
    src_now[PIN_BIT] = pin_sync;
    src_now[CMP_LSB +: NCMP] = cmp_sync;
  end

  // [R17] edge taken between controller clock ticks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      src_prev <= '0;
    else if (ctl_tick)
      src_prev <= src_now;
  end

  assign src_rise = src_now & ~src_prev;

  // [R08] reserved rising codes act as no blanking
  assign rise_blank_on = (blank_mode_t'(blanking_mode[REBM_LSB +: 2]) == BLANK_IMMEDIATE)
                         && (rise_blank_cnt != '0);
  // [R07] reserved falling codes act as no blanking
  assign fall_blank_on = (blank_mode_t'(blanking_mode[FEBM_LSB +: 2]) == BLANK_IMMEDIATE)
                         && (fall_blank_cnt != '0);

  // [R09] rising interval masks its sources
  // [R10] falling interval masks its sources
  assign blocked = (rise_blank_on ? rising_blank_sources : '0)
                 | (fall_blank_on ? falling_blank_sources : '0);

  always_comb
  begin
    // [R11] gated source transitions
    // [R13] all sources ored
    next_rise = |(src_rise & rising_event_sources & ~blocked & MASK_BLSRC);
    // [R12] timebase match with phase
    if (rising_event_sources[TB_BIT] && (timebase_counter == phase_value))
      next_rise = 1'b1;
    next_rise   = next_rise && ctl_tick;
    // [R16] period match when selected
    next_period = ctl_tick && timebase_control[PRD_TB_BIT]
                  && (timebase_counter == period_value);
    next_fall   = ctl_tick && (timebase_counter == duty_value) && !next_rise;
  end

  // [R16] timebase restarts on period event
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timebase_counter <= '0;
    else if (next_period)
      timebase_counter <= '0;
    else if (ctl_tick)
      timebase_counter <= timebase_counter + 16'h0001;
  end

  // blanking windows open on the edge they guard and count controller ticks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rise_blank_cnt <= '0;
      fall_blank_cnt <= '0;
    end
    else
    begin
      if (next_rise)
        rise_blank_cnt <= blank_time[BLANK_W-1:0];
      else if (ctl_tick && rise_blank_cnt != '0)
        rise_blank_cnt <= rise_blank_cnt - 8'h01;
      if (next_fall || next_period)
        fall_blank_cnt <= blank_time[2*BLANK_W-1:BLANK_W];
      else if (ctl_tick && fall_blank_cnt != '0)
        fall_blank_cnt <= fall_blank_cnt - 8'h01;
    end
  end

  // raw pwm level: rise wins over a coincident fall or period end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwm_level <= 1'b0;
    else if (next_rise)
      pwm_level <= 1'b1;
    else if (next_fall || next_period)
      pwm_level <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rise_event   <= 1'b0;
      fall_event   <= 1'b0;
      period_event <= 1'b0;
    end
    else
    begin
      rise_event   <= next_rise;
      fall_event   <= next_fall;
      period_event <= next_period;
    end
  end

  // ---------------- pins out ----------------
  genvar gi;
  generate
    for (gi = 0; gi < NOUT; gi++)
    begin : g_out
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pwm_out[gi]      <= 1'b0;
          pwm_drive_en[gi] <= 1'b0;
        end
        else
        begin
          // [R05] polarity inverts the active level
          pwm_out[gi]      <= pwm_level ^ output_polarity[gi];
          // [R03] enable hands pin to pwm
          pwm_drive_en[gi] <= output_enable[gi];
        end
      end
    end
  endgenerate

endmodule

//--- tb/pwm_config_monitor.sv
// assertions on the apb answer and pin outputs of pwm_config
// assumes it is bound to pwm_config and sees only its ports
`timescale 1ns/1ps
module pwm_config_monitor
  import pwm_cfg_pkg::*;
#(
  parameter bit SECOND_INSTANCE = 1'b0
) (
  input wire logic                           pclk,
  input wire logic                           presetn,
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic [pwm_cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic [pwm_cfg_pkg::DATA_W-1:0] prdata,
  input wire logic                           pready,
  input wire logic                           pslverr,
  input wire logic [pwm_cfg_pkg::NOUT-1:0]   pwm_out,
  input wire logic [pwm_cfg_pkg::NOUT-1:0]   pwm_drive_en,
  input wire logic                           rise_event,
  input wire logic                           period_event
);
  logic             rd_ok;
  logic             wr_oen;
  logic [REG_W-1:0] mask;
  assign rd_ok  = pready && !pwrite && !pslverr;
  assign wr_oen = pready && pwrite && paddr == OFS_OUTPUT_ENABLE;
  // every other register, timebase control included, is checked as if its low byte had no spare bits
  always_comb
  begin
    case (paddr)
      OFS_CLOCK_SELECT_PRESCALE: mask = MASK_CLK;
      OFS_OUTPUT_ENABLE:         mask = SECOND_INSTANCE ? MASK_OEN_TWO : MASK_OEN;
      OFS_OUTPUT_POLARITY:       mask = SECOND_INSTANCE ? MASK_POL_TWO : MASK_POL;
      OFS_BLANKING_MODE:         mask = MASK_BLNK;
      OFS_RISING_BLANK_SOURCES:  mask = MASK_BLSRC;
      OFS_FALLING_BLANK_SOURCES: mask = MASK_BLSRC;
      OFS_RISING_EVENT_SOURCES:  mask = MASK_PHS;
      default:                   mask = 8'hFF;
    endcase
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  property p_ready_next;
    s_setup |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("no pready after setup");
  property p_err_unmapped;
    s_setup ##0 (paddr > OFS_STATUS) |=> pready && pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
  property p_err_mapped;
    s_setup ##0 (paddr <= OFS_STATUS && paddr[1:0] == 2'b00) |=> !pslverr;
  endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");
  property p_upper_zero;
    rd_ok |-> prdata[31:17] == 15'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  property p_unimpl_bits;
    rd_ok |-> (prdata[7:0] & ~mask) == 8'h00;
  endproperty
  a_unimpl_bits: assert property (p_unimpl_bits) else $error("spare bit read as one");
  property p_reset_quiet;
    $rose(presetn) |-> pwm_drive_en == 6'h00 && pwm_out == 6'h00 && !rise_event && !period_event;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  property p_oen_cause;
    $changed(pwm_drive_en) |-> $past(wr_oen) || $past(wr_oen, 2);
  endproperty
  a_oen_cause: assert property (p_oen_cause) else $error("drive enable moved alone");
  property p_second_ab;
    !SECOND_INSTANCE || pwm_drive_en[5:2] == 4'h0;
  endproperty
  a_second_ab: assert property (p_second_ab) else $error("absent output enabled");
endmodule

//--- tb/power_stage_model.sv
// pad-level model of the power stage: pads, comparators and event pin
// assumes pads not handed to the pwm sit at the port latch level
`timescale 1ns/1ps
module power_stage_model
  import pwm_cfg_pkg::*;
(
  input  wire logic [pwm_cfg_pkg::NOUT-1:0] pwm_out,
  input  wire logic [pwm_cfg_pkg::NOUT-1:0] pwm_drive_en,
  input  wire logic [pwm_cfg_pkg::NOUT-1:0] port_level,
  input  wire logic [pwm_cfg_pkg::NCMP:0]   sense_cmd,
  output logic      [pwm_cfg_pkg::NOUT-1:0] pad_level,
  output logic      [pwm_cfg_pkg::NCMP-1:0] comparator_sync_out,
  output logic                              external_event_input
);
  // a released pad shows the port latch, never a stale pwm level
  assign pad_level            = (pwm_drive_en & pwm_out) | (~pwm_drive_en & port_level);
  assign comparator_sync_out  = sense_cmd[NCMP-1:0];
  assign external_event_input = sense_cmd[NCMP];
endmodule

//--- tb/test_switch_mode_pwm_config.sv
// self-checking bench for pwm_config: registers, clock choice, event sources
// assumes the first instance; tick sources run free from the bench
`timescale 1ns/1ps
module test_switch_mode_pwm_config;
  import pwm_cfg_pkg::*;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              pll_tick = 1'b0;
  logic              ext_clock_pin = 1'b0;
  logic              ext_in;
  logic [NCMP-1:0]   cmp;
  logic [NOUT-1:0]   pwm_out;
  logic [NOUT-1:0]   pwm_drive_en;
  logic [NOUT-1:0]   pad;
  logic              rise_event;
  logic              fall_event;
  logic              period_event;
  logic [NCMP:0]     sense;
  logic [1:0]        ext_div = 2'd0;
  int                miscompares;
  int                check_count;
  logic [7:0]        ck_val [7] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h01, 8'h02, 8'h03};
  int                ck_win [7] = '{42, 84, 168, 336, 84, 168, 168};
  int                ck_exp [7] = '{2, 2, 2, 2, 2, 2, 0};
  logic [7:0]        rmask  [7] = '{8'h33, 8'h3F, 8'h7F, 8'h33, 8'h9E, 8'h9E, 8'h9F};

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // pll ticks every other cycle, the clock pin rises every fourth
  always @(posedge pclk)
  begin
    pll_tick      <= ~pll_tick;
    ext_div       <= ext_div + 2'd1;
    ext_clock_pin <= ext_div[1];
  end

  pwm_config u_pwm_config (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pll_tick(pll_tick), .ext_clock_pin(ext_clock_pin), .external_event_input(ext_in),
    .comparator_sync_out(cmp), .pwm_out(pwm_out), .pwm_drive_en(pwm_drive_en),
    .rise_event(rise_event), .fall_event(fall_event), .period_event(period_event));
  power_stage_model u_power_stage_model (
    .pwm_out(pwm_out), .pwm_drive_en(pwm_drive_en), .port_level(6'h15),
    .sense_cmd(sense), .pad_level(pad), .comparator_sync_out(cmp),
    .external_event_input(ext_in));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      miscompares++;
      stop_test();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, exp);
    check({31'h0, e}, {31'h0, experr});
  endtask

  task automatic count_ev(input int cyc, output logic [31:0] nr, output logic [31:0] np);
    nr = 32'h0;
    np = 32'h0;
    repeat (cyc)
    begin
      @(negedge pclk);
      nr = nr + {31'h0, rise_event};
      np = np + {31'h0, period_event};
    end
  endtask

  // timebase rises every 21 ticks; the source edge lands between two of them
  task automatic edge_run(input logic [7:0] phs, blnk, rebs, febs, input logic [15:0] bt,
                          input logic [4:0] idle, act, input logic [31:0] exp);
    logic [31:0] nr;
    logic [31:0] np;
    int          n;
    n = 0;
    @(posedge pclk);
    sense <= idle;
    wr(OFS_RISING_EVENT_SOURCES, {24'h0, phs});
    wr(OFS_BLANKING_MODE, {24'h0, blnk});
    wr(OFS_RISING_BLANK_SOURCES, {24'h0, rebs});
    wr(OFS_FALLING_BLANK_SOURCES, {24'h0, febs});
    wr(OFS_BLANK_TIME, {16'h0, bt});
    do
    begin
      @(negedge pclk);
      n++;
    end while (rise_event !== 1'b1 && n < 2000);
    if (rise_event !== 1'b1)
      miscompares++;
    repeat (8) @(posedge pclk);
    sense <= act;
    count_ev(210, nr, np);
    check(nr, exp);
  endtask

  initial
  begin
    logic [31:0] nr;
    logic [31:0] np;
    presetn       = 1'b0;
    psel          = 1'b0;
    penable       = 1'b0;
    pwrite        = 1'b0;
    paddr         = 8'h00;
    pwdata        = 32'h0;
    sense         = 5'h00;
    miscompares   = 0;
    check_count   = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // cap the timebase first
    wr(OFS_PERIOD_VALUE, 32'd20);
    wr(OFS_TIMEBASE_CONTROL, 32'h1);
    for (int i = 0; i < 7; i++)
      rd_chk(8'(4 * i), 32'h0, 1'b0);
    rd_chk(8'h40, 32'h0, 1'b1);
    for (int i = 0; i < 7; i++)
    begin
      wr(8'(4 * i), 32'hFFFF_FFFF);
      rd_chk(8'(4 * i), {24'h0, rmask[i]}, 1'b0);
    end
    repeat (3) @(negedge pclk);
    check({26'h0, pwm_drive_en}, 32'h3F);
    check({26'h0, pwm_out}, 32'h3F);
    check({26'h0, pad}, 32'h3F);
    wr(OFS_OUTPUT_ENABLE, 32'h0);
    repeat (3) @(negedge pclk);
    check({26'h0, pad}, 32'h15);
    $display("register test done");
    wr(OFS_OUTPUT_POLARITY, 32'h0);
    wr(OFS_PHASE_VALUE, 32'h5);
    for (int i = 0; i < 7; i++)
    begin
      wr(OFS_CLOCK_SELECT_PRESCALE, {24'h0, ck_val[i]});
      repeat (400) @(posedge pclk);
      count_ev(ck_win[i], nr, np);
      check(nr, ck_exp[i]);
      check(np, ck_exp[i]);
    end
    $display("clock test done");
    wr(OFS_CLOCK_SELECT_PRESCALE, 32'h0);
    for (int i = 0; i < 4; i++)
      edge_run(8'h01 | (8'h02 << i), 0, 0, 0, 0, 5'h00, 5'h01 << i, 11);
    edge_run(8'h01, 0, 0, 0, 0, 5'h00, 5'h01, 10);
    wr(OFS_OUTPUT_POLARITY, 32'h40);
    edge_run(8'h81, 0, 0, 0, 0, 5'h10, 5'h00, 11);
    $display("source test done");
    edge_run(8'h03, 8'h01, 8'h02, 0, 16'hFFFF, 5'h10, 5'h11, 10);
    edge_run(8'h03, 8'h10, 0, 8'h02, 16'hFF00, 5'h10, 5'h11, 10);
    $display("blanking test done");
    stop_test();
  end
endmodule

bind pwm_config pwm_config_monitor #(.SECOND_INSTANCE(SECOND_INSTANCE)) u_pwm_config_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out),
  .pwm_drive_en(pwm_drive_en), .rise_event(rise_event), .period_event(period_event));
